// file: rtl/rsc_pkg.sv
/*
  constants and carrier types for the reset source controller.
  assumes a 40 MHz system clock and a word-addressed avalon-mm slave.
*/
package rsc_pkg;
  // ----------------------------------------------------------
  // bus and register map (word index)
  // ----------------------------------------------------------
  localparam int DW = 32;
  localparam int AW = 3;
  localparam logic [AW-1:0] A_FLAGS = 3'h0;
  localparam logic [AW-1:0] A_EVT   = 3'h1;
  localparam logic [AW-1:0] A_MASK  = 3'h2;
  localparam logic [AW-1:0] A_CAL   = 3'h3;
  localparam logic [AW-1:0] A_FUSE  = 3'h4;

  // ----------------------------------------------------------
  // flag register fields (active-low cause flags)
  // ----------------------------------------------------------
  localparam int FW      = 5;
  localparam int B_BROWN = 0;
  localparam int B_POR   = 1;
  localparam int B_PWRDN = 3;
  localparam int B_TMOUT = 4;
  localparam logic [FW-1:0] FLAGS_RST = 5'h1b;

  // ----------------------------------------------------------
  // sticky event bits
  // ----------------------------------------------------------
  localparam int EW      = 5;
  localparam int E_POR   = 0;
  localparam int E_BROWN = 1;
  localparam int E_WRST  = 2;
  localparam int E_WAKE  = 3;
  localparam int E_PIN   = 4;
  localparam logic [EW-1:0] EVT_RST  = 5'h00;
  localparam logic [EW-1:0] MASK_RST = 5'h00;

  // ----------------------------------------------------------
  // calibration word location in program space
  // ----------------------------------------------------------
  localparam logic [13:0] CAL_LOC = 14'h2008;

  // ----------------------------------------------------------
  // timing
  // ----------------------------------------------------------
  localparam int CLK_MHZ   = 40;
  localparam int GND_US    = 100;
  localparam int GND_CYC   = GND_US * CLK_MHZ;
  localparam int UPDLY_MS  = 64;
  localparam int UPDLY_CYC = UPDLY_MS * CLK_MHZ * 1000;
  localparam int UPDLY_W   = 22;
  localparam int FILT_CYC  = 8;

  // ----------------------------------------------------------
  // carriers
  // ----------------------------------------------------------
  typedef struct packed {
    logic ext_reset_pin_enable;
    logic powerup_delay_enable_n;
    logic brownout_enable;
  } rsc_fuse_s;

  typedef struct packed {
    logic [AW-1:0] address;
    logic          read;
    logic          write;
    logic [DW-1:0] writedata;
    logic [3:0]    byteenable;
  } rsc_avs_req_s;
endpackage : rsc_pkg

// file: rtl/rsc_reset_ctrl.sv
/*
  reset source controller: power-on, brown-out, watchdog and
  filtered external pin combined into one internal chip reset,
  with cause flags, sticky events and an interrupt.
  assumes supply monitor levels, pin and fuses are synchronous
  to clk_sys; reset_n is the block's own power-on reset.
*/
`timescale 1ns/1ps
module rsc_reset_ctrl #(
  parameter int UPDLY_CYC = rsc_pkg::UPDLY_CYC,
  parameter int CAL_W     = 8
) (
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  input  wire rsc_pkg::rsc_avs_req_s avs,
  output logic [rsc_pkg::DW-1:0]     avs_readdata_q,
  output logic                       avs_waitrequest_q,
  output logic                       irq_q,
  input  wire rsc_pkg::rsc_fuse_s    fuse,
  input  wire logic [CAL_W-1:0]      cal_fuse,
  input  wire logic                  por_supply_ok,
  input  wire logic                  supply_at_ground,
  input  wire logic                  brownout_threshold,
  input  wire logic                  watchdog_source,
  input  wire logic                  sleep_in,
  input  wire logic                  ext_reset_pin_n_in,
  output logic                       ext_reset_pin_n_out_q,
  output logic                       ext_reset_pin_n_oe_n_q,
  output logic                       pullup_en_q,
  output logic                       chip_rst_n_q,
  output logic                       wake_q,
  output logic [CAL_W-1:0]           cal_trim_q
);

  // ----------------------------------------------------------
  // power-on detector
  // ----------------------------------------------------------
  logic        armed_q;
  logic [11:0] gnd_cnt_q;
  logic        gnd_full;
  logic        por_evt;

  assign gnd_full = gnd_cnt_q == 12'(rsc_pkg::GND_CYC - 1);
  assign por_evt  = armed_q && por_supply_ok;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gnd_cnt_q <= 12'h000;
    end else if (!supply_at_ground) begin
      gnd_cnt_q <= 12'h000;
    end else if (!gnd_full) begin
      gnd_cnt_q <= gnd_cnt_q + 12'h001;
    end
  end

  // a falling supply alone never re-arms
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      armed_q <= 1'b1;
    end else if (por_evt) begin
      armed_q <= 1'b0;
    end else if (gnd_full && supply_at_ground) begin
      armed_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------
  // brown-out detect
  // ----------------------------------------------------------
  logic brownout_hold;
  logic brownout_hold_q;
  logic brownout_evt;

  assign brownout_hold = fuse.brownout_enable && !brownout_threshold;
  assign brownout_evt  = brownout_hold && !brownout_hold_q && !armed_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      brownout_hold_q <= 1'b0;
    end else begin
      brownout_hold_q <= brownout_hold;
    end
  end

  // ----------------------------------------------------------
  // power-up delay timer
  // ----------------------------------------------------------
  logic [rsc_pkg::UPDLY_W-1:0] updly_q;
  logic                        updly_run;

  assign updly_run = updly_q != '0;

  // restarts while brown-out persists, counts once supply is good
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      updly_q <= '0;
    end else if ((por_evt || brownout_hold) && !fuse.powerup_delay_enable_n) begin
      updly_q <= rsc_pkg::UPDLY_W'(UPDLY_CYC);
    end else if (updly_run) begin
      updly_q <= updly_q - rsc_pkg::UPDLY_W'(1);
    end
  end

  // ----------------------------------------------------------
  // external pin filter
  // ----------------------------------------------------------
  logic       pin_raw;
  logic       pin_filt_q;
  logic       pin_evt;
  logic [3:0] flt_cnt_q;

  assign pin_raw = fuse.ext_reset_pin_enable && !ext_reset_pin_n_in;
  assign pin_evt = pin_raw && !pin_filt_q && flt_cnt_q == 4'(rsc_pkg::FILT_CYC - 1);

  // level is taken only after it has held for the filter length
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flt_cnt_q  <= 4'h0;
      pin_filt_q <= 1'b0;
    end else if (pin_raw == pin_filt_q) begin
      flt_cnt_q <= 4'h0;
    end else if (flt_cnt_q == 4'(rsc_pkg::FILT_CYC - 1)) begin
      flt_cnt_q  <= 4'h0;
      pin_filt_q <= pin_raw;
    end else begin
      flt_cnt_q <= flt_cnt_q + 4'h1;
    end
  end

  // pin is input only; pull-up follows the enable fuse
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pullup_en_q            <= 1'b0;
      ext_reset_pin_n_out_q  <= 1'b1;
      ext_reset_pin_n_oe_n_q <= 1'b1;
    end else begin
      pullup_en_q            <= fuse.ext_reset_pin_enable;
      ext_reset_pin_n_out_q  <= 1'b1;
      ext_reset_pin_n_oe_n_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------
  // watchdog: reset when running, wake-up when asleep
  // ----------------------------------------------------------
  logic wdog_evt;
  logic wdog_rst_q;

  assign wdog_evt = watchdog_source && !armed_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wdog_rst_q <= 1'b0;
      wake_q     <= 1'b0;
    end else begin
      wdog_rst_q <= wdog_evt && !sleep_in;
      wake_q     <= wdog_evt && sleep_in;
    end
  end

  // ----------------------------------------------------------
  // chip reset combine and release
  // ----------------------------------------------------------
  logic src_act;

  // unaffected-class registers are not wired to chip_rst_n_q
  assign src_act = armed_q || brownout_hold || updly_run || pin_filt_q || wdog_rst_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      chip_rst_n_q <= 1'b0;
    end else begin
      chip_rst_n_q <= !src_act;
    end
  end

  // ----------------------------------------------------------
  // calibration trim
  // ----------------------------------------------------------
  // trim is reloaded from its fuse word, untouched by erase
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cal_trim_q <= '0;
    end else if (por_evt) begin
      cal_trim_q <= cal_fuse;
    end
  end

  // ----------------------------------------------------------
  // avalon-mm slave, one wait cycle per access
  // ----------------------------------------------------------
  logic                   acc;
  logic                   wr_acc;
  logic [7:0]             wb;
  logic [rsc_pkg::DW-1:0] rd_mux;
  logic [rsc_pkg::FW-1:0] flags_q;
  logic [rsc_pkg::EW-1:0] evt_q;
  logic [rsc_pkg::EW-1:0] mask_q;

  assign acc    = (avs.read || avs.write) && avs_waitrequest_q;
  assign wr_acc = avs.write && !avs_waitrequest_q && avs.byteenable[0];
  assign wb     = avs.writedata[7:0];

  always_comb begin
    rd_mux = '0;
    unique case (avs.address)
      rsc_pkg::A_FLAGS: rd_mux[rsc_pkg::FW-1:0] = flags_q;
      rsc_pkg::A_EVT:   rd_mux[rsc_pkg::EW-1:0] = evt_q;
      rsc_pkg::A_MASK:  rd_mux[rsc_pkg::EW-1:0] = mask_q;
      rsc_pkg::A_CAL:   rd_mux[CAL_W-1:0]       = cal_trim_q;
      rsc_pkg::A_FUSE:  rd_mux[2:0]             = fuse;
      default:          rd_mux                  = '0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest_q <= 1'b1;
      avs_readdata_q    <= '0;
    end else begin
      avs_waitrequest_q <= !acc;
      if (acc && avs.read) begin
        avs_readdata_q <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------
  // cause flags
  // ----------------------------------------------------------
  // software may set the power-on/brown-out flags; hardware wins
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= rsc_pkg::FLAGS_RST;
    end else begin
      if (wr_acc && avs.address == rsc_pkg::A_FLAGS) begin
        flags_q[rsc_pkg::B_POR]   <= flags_q[rsc_pkg::B_POR] | wb[rsc_pkg::B_POR];
        flags_q[rsc_pkg::B_BROWN] <= flags_q[rsc_pkg::B_BROWN] | wb[rsc_pkg::B_BROWN];
      end
      if (por_evt) begin
        flags_q[rsc_pkg::B_POR]   <= 1'b0;
        flags_q[rsc_pkg::B_TMOUT] <= 1'b1;
        flags_q[rsc_pkg::B_PWRDN] <= 1'b1;
      end else if (brownout_evt) begin
        flags_q[rsc_pkg::B_BROWN] <= 1'b0;
        flags_q[rsc_pkg::B_TMOUT] <= 1'b1;
        flags_q[rsc_pkg::B_PWRDN] <= 1'b1;
      end else if (wdog_evt) begin
        flags_q[rsc_pkg::B_TMOUT] <= 1'b0;
        if (sleep_in) begin
          flags_q[rsc_pkg::B_PWRDN] <= 1'b0;
        end
      end else if (pin_evt && sleep_in) begin
        flags_q[rsc_pkg::B_TMOUT] <= 1'b1;
        flags_q[rsc_pkg::B_PWRDN] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // sticky events, mask and interrupt
  // ----------------------------------------------------------
  logic [rsc_pkg::EW-1:0] new_ev;
  logic [rsc_pkg::EW-1:0] w1c;

  always_comb begin
    new_ev                   = '0;
    new_ev[rsc_pkg::E_POR]   = por_evt;
    new_ev[rsc_pkg::E_BROWN] = brownout_evt;
    new_ev[rsc_pkg::E_WRST]  = wdog_evt && !sleep_in;
    new_ev[rsc_pkg::E_WAKE]  = wdog_evt && sleep_in;
    new_ev[rsc_pkg::E_PIN]   = pin_evt;
  end

  assign w1c = (wr_acc && avs.address == rsc_pkg::A_EVT) ? wb[rsc_pkg::EW-1:0] : '0;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      evt_q <= rsc_pkg::EVT_RST;
    end else begin
      evt_q <= (evt_q & ~w1c) | new_ev;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mask_q <= rsc_pkg::MASK_RST;
    end else if (wr_acc && avs.address == rsc_pkg::A_MASK) begin
      mask_q <= wb[rsc_pkg::EW-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(evt_q & mask_q);
    end
  end

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_wdog_run;
    wdog_evt && !sleep_in;
  endsequence

  sequence s_wdog_sleep;
    wdog_evt && sleep_in;
  endsequence

  a_por_hold_rst: assert property (armed_q |=> !chip_rst_n_q)
    else $error("reset released while power-on armed");
  a_brown_hold_rst: assert property (brownout_hold |=> !chip_rst_n_q)
    else $error("reset released during brown-out");
  a_por_no_fall: assert property ((!armed_q && $fell(por_supply_ok)) |=> !armed_q)
    else $error("power-on fired on falling supply");
  a_por_rearm_time: assert property ($rose(armed_q) |-> $past(gnd_cnt_q) == 12'(rsc_pkg::GND_CYC - 1))
    else $error("power-on re-armed too early");
  a_pin_filter: assert property ($rose(pin_filt_q) |-> $past(pin_raw, 1) && $past(pin_raw, 8))
    else $error("short pin pulse accepted");
  a_pin_disabled: assert property ((!fuse.ext_reset_pin_enable && !pin_filt_q) |=> !pin_filt_q)
    else $error("pin reset while pin disabled");
  a_pullup_fuse: assert property ($past(reset_n) |-> pullup_en_q == $past(fuse.ext_reset_pin_enable))
    else $error("pull-up not following fuse");
  a_wdog_no_pin: assert property (s_wdog_run |=> ext_reset_pin_n_oe_n_q [*3])
    else $error("watchdog drove the pin");
  a_wdog_run_rst: assert property (s_wdog_run |=> !flags_q[rsc_pkg::B_TMOUT] ##1 !chip_rst_n_q)
    else $error("watchdog reset not applied");
  a_wdog_wake: assert property (s_wdog_sleep |=> wake_q && !wdog_rst_q && !flags_q[rsc_pkg::B_PWRDN])
    else $error("watchdog wake-up wrong");
  a_por_flag: assert property (por_evt |=> !flags_q[rsc_pkg::B_POR] && flags_q[rsc_pkg::B_TMOUT])
    else $error("power-on flag not cleared");
  a_updly_start: assert property ((por_evt && !fuse.powerup_delay_enable_n) |=> updly_run ##1 !chip_rst_n_q)
    else $error("power-up delay not started");
  a_rst_release: assert property (!src_act |=> chip_rst_n_q)
    else $error("reset not released");
  a_bus_ack: assert property (acc |=> !avs_waitrequest_q ##1 avs_waitrequest_q)
    else $error("bus answer timing wrong");

endmodule : rsc_reset_ctrl

// file: verif/rsc_board_model.sv
/*
  board side model: supply monitors and the reset pin network.
  assumes the bench steers supply, brown-out and pin press levels.
*/
`timescale 1ns/1ps
module rsc_board_model (
  input  wire logic clk_sys,
  input  wire logic supply_on,
  input  wire logic brown,
  input  wire logic press,
  input  wire logic pullup_en_q,
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  output logic      por_supply_ok,
  output logic      supply_at_ground,
  output logic      brownout_threshold,
  output logic      pin_n
);
  // ----------------------------------------------------------
  // supply and pin levels
  // ----------------------------------------------------------
  logic flip_q = 1'b0;
  always_ff @(posedge clk_sys) begin
    flip_q <= ~flip_q;
  end
  assign por_supply_ok      = supply_on;
  assign supply_at_ground   = ~supply_on;
  assign brownout_threshold = supply_on & ~brown;
  // a released pin without pull-up floats, so it shows a changing pattern
  assign pin_n = !pin_oe_n ? pin_out : press ? 1'b0 : pullup_en_q ? 1'b1 : flip_q;
endmodule : rsc_board_model

// file: verif/reset_source_control_test.sv
/*
  self-checking bench for the reset source controller.
  assumes rsc_board_model on the supply and pin side.
*/
`timescale 1ns/1ps
module reset_source_control_test;
  // ----------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------
  localparam int P = 20;
  rsc_pkg::rsc_avs_req_s avs;
  rsc_pkg::rsc_fuse_s    fuse;
  logic [31:0]           rdata;
  logic [31:0]           rd;
  logic [7:0]            cal;
  logic [7:0]            trim;
  logic                  clk_sys, reset_n, wreq, irq_q, wd, slp, sup, brn, pinlo;
  logic                  pok, gnd, thr, pin_n, pout, poe_n, pu, crst_n, wake;
  int                    error_cnt, comparisons, f, e, m, cnt, wk;
  integer                seed;

  rsc_reset_ctrl #(.UPDLY_CYC(P)) rsc_reset_ctrl_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .avs(avs), .avs_readdata_q(rdata),
    .avs_waitrequest_q(wreq), .irq_q(irq_q), .fuse(fuse), .cal_fuse(cal),
    .por_supply_ok(pok), .supply_at_ground(gnd), .brownout_threshold(thr),
    .watchdog_source(wd), .sleep_in(slp), .ext_reset_pin_n_in(pin_n),
    .ext_reset_pin_n_out_q(pout), .ext_reset_pin_n_oe_n_q(poe_n), .pullup_en_q(pu),
    .chip_rst_n_q(crst_n), .wake_q(wake), .cal_trim_q(trim));

  rsc_board_model rsc_board_model_i (
    .clk_sys(clk_sys), .supply_on(sup), .brown(brn), .press(pinlo), .pullup_en_q(pu),
    .pin_out(pout), .pin_oe_n(poe_n), .por_supply_ok(pok), .supply_at_ground(gnd),
    .brownout_threshold(thr), .pin_n(pin_n));

  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  // holds the request until waitrequest is seen low, then one idle edge
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs <= '{address: a, read: !w, write: w, writedata: d, byteenable: 4'h1};
    do begin
      @(posedge clk_sys);
      k++;
    end while (wreq !== 1'b0);
    chk("bus answer", k, 2);
    rd = rdata;
    avs <= '0;
    @(posedge clk_sys);
  endtask : bus

  task automatic lowcnt(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      if (crst_n === 1'b0) cnt++;
      if (wake === 1'b1) wk++;
    end
  endtask : lowcnt

  task automatic rel;
    cnt = 0;
    while (crst_n !== 1'b1 && cnt < 5000) begin
      @(posedge clk_sys);
      cnt++;
    end
  endtask : rel

  task automatic wdp;
    cnt = 0;
    wk = 0;
    wd <= 1'b1;
    @(posedge clk_sys);
    wd <= 1'b0;
    lowcnt(6);
  endtask : wdp

  task automatic pinp(input int n);
    cnt = 0;
    wk = 0;
    pinlo <= 1'b1;
    lowcnt(n);
    pinlo <= 1'b0;
    lowcnt(12);
  endtask : pinp

  task automatic regs;
    bus(0, rsc_pkg::A_FLAGS, 0);
    chk("flags", rd, f);
    bus(0, rsc_pkg::A_EVT, 0);
    chk("events", rd, e);
    chk("irq", irq_q, (e & m) != 0);
    bus(1, rsc_pkg::A_EVT, 32'h1f);
    e = 0;
    cyc(2);
    chk("irq clear", irq_q, 1'b0);
  endtask : regs

  // ----------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial begin
    #(25 * 20000);
    error_cnt++;
    wrap_up;
  end

  initial begin
    seed = 32'h699b;
    error_cnt = 0;
    comparisons = 0;
    reset_n = 1'b0;
    avs = '0;
    {wd, slp, sup, brn, pinlo} = '0;
    fuse = '{ext_reset_pin_enable: 1'b1, powerup_delay_enable_n: 1'b0, brownout_enable: 1'b1};
    cal = $random(seed);
    f = 'h1b;
    e = 0;
    m = 0;
    cyc(12);
    reset_n <= 1'b1;
    cnt = 0;
    lowcnt(20);
    chk("por hold", cnt, 20);
    sup <= 1'b1;
    rel;
    chk("power-up delay", cnt >= P, 1'b1);
    f = f & ~2;
    e = 1;
    chk("trim out", trim, cal);
    bus(0, rsc_pkg::A_CAL, 0);
    chk("trim reg", rd, cal);
    bus(0, rsc_pkg::A_FUSE, 0);
    chk("fuse reg", rd, 3'b101);
    chk("pull-up", pu, 1'b1);
    bus(0, 3'h6, 0);
    chk("unmapped", rd, 0);
    m = $random(seed) & 'h1f;
    bus(1, rsc_pkg::A_MASK, m);
    regs;
    bus(1, rsc_pkg::A_FLAGS, 3);
    f = f | 3;
    m = 'h1f;
    bus(1, rsc_pkg::A_MASK, m);
    bus(0, rsc_pkg::A_FLAGS, 0);
    chk("flags set", rd, f);
    wdp;
    chk("wdog reset", cnt, 1);
    chk("pin drive", {pout, poe_n}, 2'b11);
    f = f & ~'h10;
    e = 4;
    regs;
    slp <= 1'b1;
    wdp;
    chk("wdog wake rst", cnt, 0);
    chk("wdog wake", wk, 1);
    f = f & ~'h18;
    e = 8;
    regs;
    pinp(12);
    chk("pin sleep", cnt > 0, 1'b1);
    f = (f & ~8) | 'h10;
    e = 'h10;
    regs;
    slp <= 1'b0;
    pinp(12);
    chk("pin run", cnt > 0, 1'b1);
    e = 'h10;
    regs;
    pinp(7);
    chk("pin glitch", cnt, 0);
    regs;
    fuse.ext_reset_pin_enable <= 1'b0;
    cyc(2);
    chk("no pull-up", pu, 1'b0);
    pinp(12);
    chk("pin off", cnt, 0);
    fuse.ext_reset_pin_enable <= 1'b1;
    bus(0, rsc_pkg::A_MASK, 0);
    chk("mask kept", rd, m);
    brn <= 1'b1;
    cnt = 0;
    lowcnt(10);
    chk("brown hold", cnt >= 8, 1'b1);
    brn <= 1'b0;
    rel;
    chk("brown delay", cnt >= P, 1'b1);
    f = (f & ~1) | 'h18;
    e = 2;
    regs;
    fuse.brownout_enable <= 1'b0;
    cnt = 0;
    sup <= 1'b0;
    lowcnt(50);
    sup <= 1'b1;
    lowcnt(10);
    chk("dip ignored", cnt, 0);
    regs;
    sup <= 1'b0;
    cyc(rsc_pkg::GND_CYC + 20);
    chk("re-armed", crst_n, 1'b0);
    sup <= 1'b1;
    rel;
    chk("por delay", cnt >= P, 1'b1);
    f = (f & ~2) | 'h18;
    e = 1;
    regs;
    fuse <= '{ext_reset_pin_enable: 1'b1, powerup_delay_enable_n: 1'b1, brownout_enable: 1'b1};
    brn <= 1'b1;
    cyc(10);
    brn <= 1'b0;
    rel;
    chk("no delay", cnt < P, 1'b1);
    e = 2;
    regs;
    wrap_up;
  end
endmodule : reset_source_control_test
